// >>> hdl/lic_defs.svh
// Purpose: Constants of the LCD icon RAM and instruction control block
// Assumes: 50 MHz system clock
// Notes: Definitions only
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define LIC_CLK_NS 20
`define LIC_T_BOOT_NS 10000000
`define LIC_T_HOLD_NS 1200000
`define LIC_T_CLR_NS 2890000
`define LIC_T_INS_NS 223000
`define LIC_T_RD_NS 312000

// ****************************************
// Register offsets
// ****************************************
`define LIC_OFF_INSTR 8'h00
`define LIC_OFF_DATA 8'h04

// ****************************************
// Geometry and addresses
// ****************************************
`define LIC_NCHR 12
`define LIC_NSEG 30
`define LIC_NCOM 17
`define LIC_NICON 24
`define LIC_CNT_W 20
`define LIC_SPACE 8'h20
`define LIC_GLYPH_SEL 2'h2
`define LIC_ICON_SEL 4'hc
`define LIC_ICON_WORDS 3'h5
`define LIC_ICON_LINE 5'h10
`define LIC_LAST_SEG 5'h1d

`endif

// >>> hdl/lic_pkg.sv
// Purpose: Types of the LCD icon RAM and instruction control block
// Assumes: lic_defs.svh holds the counter width and display geometry
// Notes: No logic here
`include "lic_defs.svh"
`default_nettype none

package lic_pkg;

    typedef enum logic [0:0] {
        LIC_IDLE = 1'b0,
        LIC_EXEC = 1'b1
    } lic_state_t;

    typedef struct packed {
        lic_state_t state;
        logic [`LIC_CNT_W-1:0] cnt;
        logic [6:0] ac;
        logic inc;
        logic sh_en;
        logic disp;
        logic cur;
        logic blk;
        logic [3:0] shift;
        logic [`LIC_NCHR-1:0][7:0] dd;
        logic [`LIC_CNT_W-1:0] low_cnt;
        logic armed;
        logic [31:0] rdata;
        logic [7:0] div;
        logic [4:0] bit_idx;
        logic lat_pend;
        logic [4:0] line;
        logic [4:0] lline;
        logic [`LIC_NCOM-1:0] com;
        logic latch;
        logic shift_p;
        logic sbit;
        logic [7:0] frames;
        logic blink_ph;
    } lic_st_t;

    typedef struct packed {
        logic [`LIC_NSEG-1:0] sh;
        logic [`LIC_NSEG-1:0] lat;
    } lic_seg_t;

endpackage

`default_nettype wire

// >>> hdl/lic_seg_latch.sv
// Purpose: Segment shift register with output latch
// Assumes: One bit shifted per shift pulse, MSB side first
// Notes: Latch copies the shift register on the latch pulse
`include "lic_defs.svh"
`default_nettype none

module lic_seg_latch #(
    parameter int W = `LIC_NSEG
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Serial pattern
    input wire logic i_shift,
    input wire logic i_bit,
    input wire logic i_latch,
    // Segment data
    output logic [W-1:0] o_seg
);

    lic_pkg::lic_seg_t st_r;
    lic_pkg::lic_seg_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_shift) begin
            st_nxt.sh = {st_r.sh[`LIC_NSEG-2:0], i_bit};
        end
        if (i_latch) begin
            st_nxt.lat = st_r.sh;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_seg = st_r.lat[W-1:0];

endmodule // lic_seg_latch

`default_nettype wire

// >>> hdl/lic_core.sv
// Purpose: Icon RAM, instruction control and display refresh of a 12-character LCD driver
// Assumes: APB slave, inputs synchronous to I_CLK, font ROM outside
// Notes: Icon and glyph RAM have no reset
//
// Added by the designer: the APB register port and the register addresses.
`include "lic_defs.svh"
`default_nettype none

// Summary of operation
// R1: Each set icon RAM bit 0..4 lights its icon except bit 0 of word 4, 24 icons in five words.
// R2: Icons change only by icon RAM writes or display on/off.
// R3: Icon to segment mapping ignores display shift.
// R4: Bit 4 is the lowest icon of a word, bit 0 highest; bits 7..5 ignored.
// R5: Icon RAM is not cleared by power-on or hardware reset.
// R6: Refresh reads run apart from host access timing.
// R7: 17 commons, 30 segments; only the scanned common is selected.
// R8: Segment data shifts 30 bits, then latches to the outputs.
// R9: Cursor and blink sit at the pointer digit, anywhere when pointing at glyph RAM.
// R10: Power-up runs initialization with busy held 10 ms.
// R11: Reset pin low over 1.2 ms restarts init, busy 10 ms after release.
// R12: Without power-on init the host initializes by instructions.
// R13: Instruction and data latches chosen by register select, with direction.
// R14: Host never sends the all-zero test code.
// R15: Code 0x01 clears the display, pointer to 0, busy 2.89 ms.
// R16: Code 0x02 homes pointer and shift, keeps display RAM, 223 us.
// R17: Code 0x04 sets increment/decrement and display shift with accesses.
// R18: Clear writes spaces everywhere and forces increment, shift setting kept.
// R19: Busy read returns busy flag with the address pointer.
// R20: Host polls busy or waits the execution time before the next access.
module lic_core #(
    parameter int P_BOOT_CYC = (`LIC_T_BOOT_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS,
    parameter int P_HOLD_CYC = (`LIC_T_HOLD_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS,
    parameter int P_CLR_CYC = (`LIC_T_CLR_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS,
    parameter int P_INS_CYC = (`LIC_T_INS_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS,
    parameter int P_RD_CYC = (`LIC_T_RD_NS + `LIC_CLK_NS - 1) / `LIC_CLK_NS,
    parameter int P_SCAN_DIV = 16,
    parameter int P_BLINK_FRAMES = 16
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RESET_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // LCD drive
    output logic [`LIC_NCOM-1:0] O_COM,
    output logic [`LIC_NSEG-1:0] O_SEG,
    output logic O_BUSY
);

    // ****************************************
    // State
    // ****************************************
    localparam lic_pkg::lic_st_t ST_RST = '{state: lic_pkg::LIC_EXEC, cnt: `LIC_CNT_W'(P_BOOT_CYC - 1),
        dd: {`LIC_NCHR{`LIC_SPACE}}, inc: 1'b1, bit_idx: `LIC_LAST_SEG, default: '0};
    localparam logic [4:0] ICON_SEG [`LIC_NICON] = '{5'h01, 5'h03, 5'h06, 5'h08, 5'h0b, 5'h0d,
        5'h10, 5'h12, 5'h15, 5'h17, 5'h1a, 5'h1c, 5'h02, 5'h04, 5'h07, 5'h09, 5'h0c, 5'h0e,
        5'h11, 5'h13, 5'h16, 5'h18, 5'h1b, 5'h1d};

    lic_pkg::lic_st_t st_r;
    lic_pkg::lic_st_t st_nxt;
    logic [4:0] icon_mem [`LIC_ICON_WORDS];
    logic [4:0] glyph_mem [32];
    logic busy, setup, access, sel_ins, sel_dat, refuse, ins_wr, dat_wr, dat_rd;
    logic we_icon, we_glyph, in_icon;
    logic [7:0] wdata, ram_rd;
    logic [`LIC_NSEG-1:0] icon_hot [`LIC_NICON];
    logic [`LIC_NSEG-1:0] icon_vec, char_vec, line_vec;

    function automatic logic [6:0] lic_step(input logic [6:0] a, input logic up);
        logic [6:0] r;
        if (a < 7'(`LIC_NCHR)) begin
            if (up) begin
                r = (a == 7'(`LIC_NCHR - 1)) ? 7'h00 : a + 7'h01;
            end else begin
                r = (a == 7'h00) ? 7'(`LIC_NCHR - 1) : a - 7'h01;
            end
        end else begin
            r = up ? a + 7'h01 : a - 7'h01;
        end
        return r;
    endfunction

    function automatic logic [3:0] lic_rot(input logic [3:0] s, input logic up);
        logic [3:0] r;
        if (up) begin
            r = (s == 4'(`LIC_NCHR - 1)) ? 4'h0 : s + 4'h1;
        end else begin
            r = (s == 4'h0) ? 4'(`LIC_NCHR - 1) : s - 4'h1;
        end
        return r;
    endfunction

    // ****************************************
    // Host access decode
    // ****************************************
    assign busy = st_r.state == lic_pkg::LIC_EXEC;
    assign setup = I_PSEL & ~I_PENABLE;
    assign access = I_PSEL & I_PENABLE;
    assign sel_ins = I_PADDR == `LIC_OFF_INSTR;
    assign sel_dat = I_PADDR == `LIC_OFF_DATA;
    assign refuse = access & (~(sel_ins | sel_dat) | (busy & (sel_dat | I_PWRITE)));
    assign ins_wr = access & ~refuse & sel_ins & I_PWRITE; // R13
    assign dat_wr = access & ~refuse & sel_dat & I_PWRITE; // R13
    assign dat_rd = access & ~refuse & sel_dat & ~I_PWRITE;
    assign wdata = I_PWDATA[7:0];
    assign in_icon = (st_r.ac[6:3] == `LIC_ICON_SEL) && (st_r.ac[2:0] < `LIC_ICON_WORDS);
    assign we_icon = dat_wr & in_icon;
    assign we_glyph = dat_wr & (st_r.ac[6:5] == `LIC_GLYPH_SEL);

    always_comb begin
        if (st_r.ac < 7'(`LIC_NCHR)) begin
            ram_rd = st_r.dd[st_r.ac[3:0]];
        end else if (in_icon) begin
            ram_rd = {3'h0, icon_mem[st_r.ac[2:0]]};
        end else if (st_r.ac[6:5] == `LIC_GLYPH_SEL) begin
            ram_rd = {3'h0, glyph_mem[st_r.ac[4:0]]};
        end else begin
            ram_rd = 8'h00;
        end
    end

    // Icon and glyph RAM, no reset
    always_ff @(posedge I_CLK) begin
        if (we_icon) begin
            icon_mem[st_r.ac[2:0]] <= wdata[4:0]; // R1 R4 R5
        end
        if (we_glyph) begin
            glyph_mem[st_r.ac[4:0]] <= wdata[4:0];
        end
    end

    // ****************************************
    // Refresh pattern
    // ****************************************
    genvar k;
    generate
        for (k = 0; k < `LIC_NICON; k++) begin : g_icon
            assign icon_hot[k] = icon_mem[k / 5][4 - (k % 5)] ? (`LIC_NSEG'(1) << ICON_SEG[k]) : '0; // R3 R4
        end
        for (k = 0; k < 6; k++) begin : g_chr
            logic [4:0] sum, addr, pat;
            logic [7:0] code;
            logic hit;
            assign sum = 5'(k) + (st_r.line[3] ? 5'h06 : 5'h00) + {1'b0, st_r.shift};
            assign addr = (sum >= 5'(`LIC_NCHR)) ? sum - 5'(`LIC_NCHR) : sum;
            assign code = st_r.dd[addr[3:0]];
            assign hit = addr[3:0] == st_r.ac[3:0]; // R9
            always_comb begin
                pat = (code[7:4] == 4'h0) ? glyph_mem[{code[1:0], st_r.line[2:0]}] : 5'h00;
                if (st_r.cur && hit && st_r.line[2:0] == 3'h7) begin
                    pat = 5'h1f; // R9
                end
                if (st_r.blk && hit && st_r.blink_ph) begin
                    pat = 5'h1f; // R9
                end
            end
            assign char_vec[k*5 +: 5] = {pat[0], pat[1], pat[2], pat[3], pat[4]};
        end
    endgenerate

    always_comb begin
        icon_vec = '0;
        for (int i = 0; i < `LIC_NICON; i++) begin
            icon_vec = icon_vec | icon_hot[i]; // R1
        end
        if (!st_r.disp) begin
            line_vec = '0; // R2
        end else if (st_r.line == `LIC_ICON_LINE) begin
            line_vec = icon_vec;
        end else begin
            line_vec = char_vec;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic go;
        logic [`LIC_CNT_W-1:0] go_cnt;
        go = 1'b0;
        go_cnt = '0;
        st_nxt = st_r;
        st_nxt.latch = 1'b0;
        st_nxt.shift_p = 1'b0;
        // Execution timer
        if (busy) begin
            if (st_r.cnt == '0) begin
                st_nxt.state = lic_pkg::LIC_IDLE;
            end else begin
                st_nxt.cnt = st_r.cnt - `LIC_CNT_W'(1);
            end
        end
        if (setup && !I_PWRITE) begin
            if (sel_ins) begin
                st_nxt.rdata = {24'h0000_00, busy, st_r.ac}; // R19
            end else if (sel_dat) begin
                st_nxt.rdata = {24'h0000_00, ram_rd};
            end else begin
                st_nxt.rdata = '0;
            end
        end
        // Instructions
        if (ins_wr) begin
            go_cnt = `LIC_CNT_W'(P_INS_CYC - 1);
            if (wdata[7]) begin
                st_nxt.ac = wdata[6:0];
                go = 1'b1;
            end else if (wdata[6:5] != 2'h0) begin
                go = 1'b0;
            end else if (wdata[4]) begin
                if (wdata[3]) begin
                    st_nxt.shift = lic_rot(st_r.shift, ~wdata[2]);
                end else begin
                    st_nxt.ac = lic_step(st_r.ac, wdata[2]);
                end
                go_cnt = `LIC_CNT_W'(P_RD_CYC - 1);
                go = 1'b1;
            end else if (wdata[3]) begin
                st_nxt.disp = wdata[2]; // R2
                st_nxt.cur = wdata[1];
                st_nxt.blk = wdata[0];
                go = 1'b1;
            end else if (wdata[2]) begin
                st_nxt.inc = wdata[1]; // R17
                st_nxt.sh_en = wdata[0]; // R17
                go = 1'b1;
            end else if (wdata[1]) begin
                st_nxt.ac = '0; // R16
                st_nxt.shift = '0; // R16
                go = 1'b1;
            end else if (wdata[0]) begin
                st_nxt.dd = {`LIC_NCHR{`LIC_SPACE}}; // R15 R18
                st_nxt.ac = '0; // R15
                st_nxt.inc = 1'b1; // R18
                go_cnt = `LIC_CNT_W'(P_CLR_CYC - 1); // R15
                go = 1'b1;
            end
        end
        // Data accesses
        if (dat_wr || dat_rd) begin
            if (dat_wr && st_r.ac < 7'(`LIC_NCHR)) begin
                st_nxt.dd[st_r.ac[3:0]] = wdata;
            end
            st_nxt.ac = lic_step(st_r.ac, st_r.inc);
            if (st_r.sh_en) begin
                st_nxt.shift = lic_rot(st_r.shift, st_r.inc);
            end
            go_cnt = `LIC_CNT_W'(dat_wr ? P_INS_CYC - 1 : P_RD_CYC - 1);
            go = 1'b1;
        end
        if (go) begin
            st_nxt.state = lic_pkg::LIC_EXEC;
            st_nxt.cnt = go_cnt;
        end
        // Reset pin
        if (!I_RESET_N) begin
            if (st_r.low_cnt < `LIC_CNT_W'(P_HOLD_CYC)) begin
                st_nxt.low_cnt = st_r.low_cnt + `LIC_CNT_W'(1);
            end else begin
                st_nxt.armed = 1'b1; // R11
            end
        end else begin
            st_nxt.low_cnt = '0;
        end
        if (st_r.armed) begin
            st_nxt.state = lic_pkg::LIC_EXEC; // R11
            st_nxt.cnt = `LIC_CNT_W'(P_BOOT_CYC - 1); // R11
            if (I_RESET_N) begin
                st_nxt.armed = 1'b0;
                st_nxt.dd = {`LIC_NCHR{`LIC_SPACE}};
                st_nxt.ac = '0;
                st_nxt.inc = 1'b1;
                st_nxt.sh_en = 1'b0;
                st_nxt.shift = '0;
                st_nxt.disp = 1'b0;
                st_nxt.cur = 1'b0;
                st_nxt.blk = 1'b0;
            end
        end
        // Refresh scan, free of host timing
        if (st_r.div == 8'h00) begin // R6
            st_nxt.div = 8'(P_SCAN_DIV - 1);
            if (st_r.lat_pend) begin
                st_nxt.lat_pend = 1'b0;
                st_nxt.latch = 1'b1; // R8
                st_nxt.lline = st_r.line;
                st_nxt.line = (st_r.line == `LIC_ICON_LINE) ? 5'h00 : st_r.line + 5'h01;
                if (st_r.line == `LIC_ICON_LINE) begin
                    if (st_r.frames == 8'h00) begin
                        st_nxt.frames = 8'(P_BLINK_FRAMES - 1);
                        st_nxt.blink_ph = ~st_r.blink_ph;
                    end else begin
                        st_nxt.frames = st_r.frames - 8'h01;
                    end
                end
            end else begin
                st_nxt.shift_p = 1'b1;
                st_nxt.sbit = line_vec[st_r.bit_idx];
                if (st_r.bit_idx == 5'h00) begin
                    st_nxt.bit_idx = `LIC_LAST_SEG;
                    st_nxt.lat_pend = 1'b1; // R8
                end else begin
                    st_nxt.bit_idx = st_r.bit_idx - 5'h01;
                end
            end
        end else begin
            st_nxt.div = st_r.div - 8'h01;
        end
        if (st_r.latch) begin
            st_nxt.com = `LIC_NCOM'(1) << st_r.lline; // R7
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r <= ST_RST; // R10
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    lic_seg_latch #(.W(`LIC_NSEG)) u_seg (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_shift(st_r.shift_p),
        .i_bit(st_r.sbit),
        .i_latch(st_r.latch),
        .o_seg(O_SEG)
    );

    assign O_PRDATA = st_r.rdata;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = refuse;
    assign O_COM = st_r.com;
    assign O_BUSY = busy;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    logic [5:0] sh_cnt_r;
    logic [4:0] icon_wr_r;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            icon_wr_r <= '0;
        end else if (we_icon) begin
            icon_wr_r[st_r.ac[2:0]] <= 1'b1;
        end
    end
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sh_cnt_r <= '0;
        end else if (st_r.latch) begin
            sh_cnt_r <= 6'(st_r.shift_p);
        end else if (st_r.shift_p) begin
            sh_cnt_r <= sh_cnt_r + 6'h01;
        end
    end

    property p_clear;
        ins_wr && wdata == 8'h01 |=> st_r.ac == 7'h00 && st_r.inc && st_r.dd[11] == `LIC_SPACE
            && busy && st_r.cnt == `LIC_CNT_W'(P_CLR_CYC - 1) && st_r.sh_en == $past(st_r.sh_en);
    endproperty
    a_clear: assert property (p_clear) else $error("clear display wrong"); // R15
    property p_home;
        ins_wr && wdata[7:1] == 7'h01 |=> st_r.ac == 7'h00 && st_r.shift == 4'h0 && st_r.dd == $past(st_r.dd);
    endproperty
    a_home: assert property (p_home) else $error("return home wrong"); // R16
    property p_entry;
        ins_wr && wdata[7:2] == 6'h01 |=> st_r.inc == $past(wdata[1]) && st_r.sh_en == $past(wdata[0]) && busy;
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode wrong"); // R17
    property p_status;
        setup && sel_ins && !I_PWRITE |=> O_PRDATA[7] == $past(busy) && O_PRDATA[6:0] == $past(st_r.ac);
    endproperty
    a_status: assert property (p_status) else $error("busy read wrong"); // R19
    property p_hwrst;
        I_RESET_N && st_r.armed |=> busy && st_r.cnt == `LIC_CNT_W'(P_BOOT_CYC - 1) && !st_r.armed;
    endproperty
    a_hwrst: assert property (p_hwrst) else $error("reset pin restart wrong"); // R11
    property p_latch30;
        st_r.latch |-> sh_cnt_r == 6'h1e;
    endproperty
    a_latch30: assert property (p_latch30) else $error("latch before 30 shifts"); // R8
    property p_com;
        $onehot0(O_COM) and (st_r.latch |=> $onehot(O_COM));
    endproperty
    a_com: assert property (p_com) else $error("common select not one-hot"); // R7
    property p_icon_stable;
        !we_icon && (&icon_wr_r) |=> $stable(icon_vec);
    endproperty
    a_icon_stable: assert property (p_icon_stable) else $error("icons changed without write"); // R2
    property p_icon_map;
        we_icon && st_r.ac[2:0] == 3'h0 |=> icon_vec[ICON_SEG[0]] == $past(wdata[4]);
    endproperty
    a_icon_map: assert property (p_icon_map) else $error("icon bit mapping wrong"); // R4

    c_clear: cover property (ins_wr && wdata == 8'h01);
    c_icon: cover property (we_icon);
    c_hwrst: cover property (st_r.armed ##1 !st_r.armed);
    c_latch: cover property (st_r.latch && st_r.lline == `LIC_ICON_LINE);

endmodule // lic_core

`default_nettype wire

// >>> sim/lic_host.sv
// Purpose: APB master standing in for the host processor
// Assumes: Slave answers through pready
// Notes: Released address and data show the inverse of the last value
`default_nettype none

module lic_host (
    // Clock
    input wire logic i_clk,
    // APB
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0000_0000;
    end

    // ****************************************
    // One transfer; the all-zero code is never sent
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule // lic_host

`default_nettype wire

// >>> sim/lic_core_test.sv
// Purpose: Self-checking bench of lic_core
// Assumes: Shortened counts
// Notes: Host model drives the APB side
`default_nettype none

module lic_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BOOT = 200;
    localparam int CLR = 50;
    localparam int INS = 10;
    localparam int RD = 12;
    logic clk, arst_n, rst_n, psel, pen, pwr, pready, perr, busy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [16:0] com;
    logic [29:0] seg;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;

    lic_core #(.P_BOOT_CYC(BOOT), .P_HOLD_CYC(20), .P_CLR_CYC(CLR), .P_INS_CYC(INS), .P_RD_CYC(RD),
        .P_SCAN_DIV(2), .P_BLINK_FRAMES(2)) dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_RESET_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr), .O_COM(com), .O_SEG(seg), .O_BUSY(busy));
    lic_host u_host (.i_clk(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
        .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(perr));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic conclude();
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic busy_len(input int x);
        int n;
        n = 0;
        tick();
        while (busy === 1'b1 && n < 5000) begin
            n++;
            tick();
        end
        chk("busy cycles", 1, 32'((n >= x - 3) && (n <= x + 3)));
    endtask
    task automatic op(input logic [7:0] a, input logic [7:0] d, input int x);
        u_host.xfer(1'b1, a, {24'h0, d}, r, e);
        chk("write error", 0, {31'h0, e});
        busy_len(x);
    endtask
    task automatic stat(input logic [7:0] x);
        u_host.xfer(1'b0, 8'h00, 32'h0, r, e);
        chk("status", {24'h0, x}, r);
    endtask
    task automatic rdd(input logic [7:0] x);
        u_host.xfer(1'b0, 8'h04, 32'h0, r, e);
        chk("data read", {24'h0, x}, r);
        busy_len(RD);
    endtask
    task automatic icon(input logic [29:0] x, input int ln = 16);
        repeat (2) begin
            while (com[ln] !== 1'b1) tick();
            while (com[ln] === 1'b1) tick();
        end
        while (com[ln] !== 1'b1) tick();
        chk("common", 32'h0000_0001 << ln, {15'h0, com});
        chk("segments", {2'h0, x}, {2'h0, seg});
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk("boot busy", 1, {31'h0, busy});
        busy_len(BOOT);
        op(8'h00, 8'h01, CLR);
        op(8'h00, 8'h83, INS);
        op(8'h04, 8'h41, INS);
        stat(8'h04);
        op(8'h00, 8'h04, INS);
        op(8'h04, 8'h42, INS);
        stat(8'h03);
        op(8'h00, 8'h02, INS);
        stat(8'h00);
        op(8'h00, 8'h83, INS);
        rdd(8'h41);
        stat(8'h02);
        op(8'h00, 8'h01, CLR);
        stat(8'h00);
        op(8'h00, 8'h83, INS);
        rdd(8'h20);
        stat(8'h04);
        u_host.xfer(1'b0, 8'h08, 32'h0, r, e);
        chk("unmapped error", 1, {31'h0, e});
        chk("unmapped data", 0, r);
        op(8'h00, 8'he0, INS);
        for (int k = 0; k < 5; k++) begin
            op(8'h04, (k == 0) ? 8'h10 : ((k == 4) ? 8'he0 : 8'h00), INS);
        end
        op(8'h00, 8'h0c, INS);
        icon(30'h0000_0002);
        op(8'h00, 8'h18, RD);
        icon(30'h0000_0002);
        op(8'h00, 8'he3, INS);
        op(8'h04, 8'h01, INS);
        icon(30'h0008_0002);
        op(8'h00, 8'h08, INS);
        icon(30'h0000_0000);
        op(8'h00, 8'h85, INS);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (25) @(posedge clk);
        rst_n <= 1'b1;
        u_host.xfer(1'b1, 8'h00, 32'h0000_0001, r, e);
        chk("busy write error", 1, {31'h0, e});
        busy_len(BOOT - 3);
        stat(8'h00);
        op(8'h00, 8'h0e, INS);
        icon(30'h0000_001f, 7);
        conclude();
    end
endmodule // lic_core_test

`default_nettype wire
